/* logic/cdg_pkg.sv */
`default_nettype none
package cdg_pkg;
   // Register indices; byte address is index shifted left by ADDR_SHIFT
   localparam logic [7:0]  IDX_PB_LEFT    = 8'h1E;
   localparam logic [7:0]  IDX_PB_RIGHT   = 8'h1F;
   localparam logic [7:0]  IDX_SIDETONE   = 8'h20;
   localparam logic [7:0]  IDX_COND       = 8'h21;
   localparam logic [7:0]  IDX_REC_LEFT   = 8'h24;
   localparam logic [7:0]  IDX_REC_RIGHT  = 8'h25;
   localparam logic [7:0]  IDX_STATUS     = 8'h30;
   localparam int          ADDR_SHIFT     = 2;

   // Volume codes
   localparam logic [7:0]  GAIN_RESET     = 8'hC0;
   localparam logic [7:0]  GAIN_UNITY     = 8'hC0;
   localparam logic [7:0]  REC_GAIN_MAX   = 8'hEF;
   localparam logic [7:0]  GAIN_MUTE      = 8'h00;
   localparam int          APPLY_BIT      = 8;

   // Sidetone register fields
   localparam int          ST_LEVEL_L_LSB = 8;
   localparam int          ST_LEVEL_R_LSB = 4;
   localparam int          ST_SRC_L_LSB   = 2;
   localparam int          ST_SRC_R_LSB   = 0;
   localparam logic [3:0]  ST_LEVEL_FULL  = 4'hC;
   localparam logic [7:0]  ST_GAIN_BASE   = 8'h60;
   localparam logic [15:0] ST_MASK        = 16'h0FFF;
   typedef enum logic [1:0] {
      CDG_SRC_NONE      = 2'h0,
      CDG_SRC_REC_LEFT  = 2'h1,
      CDG_SRC_REC_RIGHT = 2'h2,
      CDG_SRC_RESERVED  = 2'h3
   } cdg_src_t;

   // Conditioning register fields
   localparam int          COND_MONO      = 12;
   localparam int          COND_SLOPED    = 11;
   localparam int          COND_SPEED     = 10;
   localparam int          COND_UNSIL     = 9;
   localparam int          COND_SILENCE   = 3;
   localparam int          COND_PRE_EMPHASIS_UNDO_SELECT    = 1;
   localparam int          COND_OSR       = 0;
   localparam logic [15:0] COND_MASK      = 16'h1E0F;
   localparam logic [15:0] COND_RESET     = 16'h0000;

   // Ramp steps once per this many accepted samples plus one
   localparam logic [4:0]  RAMP_FAST_LAST = 5'h01;
   localparam logic [4:0]  RAMP_SLOW_LAST = 5'h1F;

   // Gain arithmetic: code + offset = 16*octave + fraction, mantissa in Q14
   localparam logic [8:0]  GAIN_OFFSET    = 9'h040;
   localparam logic [5:0]  GAIN_SHIFT_BASE = 6'h1E;
   localparam logic [15:0] MANT [16] = '{
      16'h4000, 16'h42D3, 16'h45C6, 16'h48DC, 16'h4C11, 16'h4F6E, 16'h52EE, 16'h5698,
      16'h5A67, 16'h5E67, 16'h628E, 16'h66E8, 16'h6B71, 16'h7031, 16'h7522, 16'h7A4E
   };
endpackage
`default_nettype wire

/* logic/cdg_gain_core.sv */
// Added by the designer: the APB register port.
`default_nettype none
module cdg_gain_core #(
   parameter int SW    = 16,
   parameter int DEPTH = 2
) (
   input  wire logic          core_clk_i,
   input  wire logic          sys_rst_i,
   input  wire logic          psel_i,
   input  wire logic          penable_i,
   input  wire logic          pwrite_i,
   input  wire logic [9:0]    paddr_i,
   input  wire logic [31:0]   pwdata_i,
   input  wire logic [3:0]    pstrb_i,
   output logic      [31:0]   prdata_o,
   output logic               pready_o,
   output logic               pslverr_o,
   input  wire logic          in_valid_i,
   output logic               in_ready_o,
   input  wire logic [SW-1:0] pb_left_i,
   input  wire logic [SW-1:0] pb_right_i,
   input  wire logic [SW-1:0] rec_left_i,
   input  wire logic [SW-1:0] rec_right_i,
   output logic               out_valid_o,
   input  wire logic          out_ready_i,
   output logic      [SW-1:0] pb_left_o,
   output logic      [SW-1:0] pb_right_o,
   output logic      [SW-1:0] rec_left_o,
   output logic      [SW-1:0] rec_right_o,
   output logic               sloped_filter_o,
   output logic      [1:0]    pre_emphasis_undo_o,
   output logic               oversample_rate_o
);
   localparam int FW = 4 * SW;

   // Clip a widened sample back into the signed sample range
   function automatic logic [SW-1:0] sat(input logic signed [SW+16:0] v);
      logic signed [SW+16:0] hi;
      logic signed [SW+16:0] lo;
      hi = (SW+17)'(signed'((1 <<< (SW-1)) - 1));
      lo = -hi - (SW+17)'(1);
      if (v > hi)
         sat = hi[SW-1:0];
      else if (v < lo)
         sat = lo[SW-1:0];
      else
         sat = v[SW-1:0];
   endfunction

   // Scale a sample by a 0.375dB-step volume code; code 00 is silence
   function automatic logic [SW-1:0] gain(input logic [SW-1:0] s, input logic [7:0] code);
      logic [8:0]            n;
      logic [5:0]            sh;
      logic signed [SW+16:0] prod;
      n    = {1'b0, code} + cdg_pkg::GAIN_OFFSET;
      sh   = cdg_pkg::GAIN_SHIFT_BASE - {1'b0, n[8:4]};
      prod = $signed(s) * $signed({1'b0, cdg_pkg::MANT[n[3:0]]});
      gain = (code == cdg_pkg::GAIN_MUTE) ? '0 : sat(prod >>> sh);
   endfunction

   // Codes past the ceiling act as the ceiling
   function automatic logic [7:0] clamp(input logic [7:0] c, input logic [7:0] top);
      clamp = (c > top) ? top : c;
   endfunction

   // Sidetone level in volume-code units: 3dB is eight 0.375dB steps
   function automatic logic [7:0] st_code(input logic [3:0] lvl);
      st_code = (lvl >= cdg_pkg::ST_LEVEL_FULL) ? cdg_pkg::GAIN_UNITY
              : cdg_pkg::ST_GAIN_BASE + {1'b0, lvl, 3'h0};
   endfunction

   // Pick the record channel that feeds a playback channel
   function automatic logic [SW-1:0] st_pick(input logic [1:0] src, input logic [SW-1:0] l,
                                              input logic [SW-1:0] r);
      case (cdg_pkg::cdg_src_t'(src))
         cdg_pkg::CDG_SRC_REC_LEFT:  st_pick = l;
         cdg_pkg::CDG_SRC_REC_RIGHT: st_pick = r;
         default:                    st_pick = '0;
      endcase
   endfunction

   // Saturating sum of two samples
   function automatic logic [SW-1:0] add(input logic [SW-1:0] a, input logic [SW-1:0] b);
      logic signed [SW+16:0] v;
      v   = (SW+17)'($signed(a)) + (SW+17)'($signed(b));
      add = sat(v);
   endfunction

   // One volume step toward the target
   function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] t);
      step = (c < t) ? c + 8'h01 : (c > t) ? c - 8'h01 : c;
   endfunction

   // Merge a write into a 16-bit register under byte strobes and a mask
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
      logic [15:0] w;
      w[7:0]  = pstrb_i[0] ? pwdata_i[7:0] : old[7:0];
      w[15:8] = pstrb_i[1] ? pwdata_i[15:8] : old[15:8];
      merge   = w & mask;
   endfunction

   // APB decode; registers sit on word boundaries
   logic [7:0]  idx;
   logic        aligned;
   logic        setup;
   logic        access;
   logic        wr_en;
   logic        hit;
   assign idx     = paddr_i[9:cdg_pkg::ADDR_SHIFT];
   assign aligned = (paddr_i[1:0] == 2'h0);
   assign setup   = psel_i && !penable_i;
   assign access  = psel_i && penable_i;
   assign hit     = aligned && (idx == cdg_pkg::IDX_PB_LEFT || idx == cdg_pkg::IDX_PB_RIGHT
                 || idx == cdg_pkg::IDX_SIDETONE || idx == cdg_pkg::IDX_COND
                 || idx == cdg_pkg::IDX_REC_LEFT || idx == cdg_pkg::IDX_REC_RIGHT
                 || idx == cdg_pkg::IDX_STATUS);
   assign wr_en   = access && pwrite_i && hit;
   assign pready_o  = 1'b1;                  // Zero wait states
   assign pslverr_o = access && !hit;

   logic wr_pb_l;
   logic wr_pb_r;
   logic wr_rec_l;
   logic wr_rec_r;
   logic pb_apply;
   logic rec_apply;
   assign wr_pb_l  = wr_en && idx == cdg_pkg::IDX_PB_LEFT;
   assign wr_pb_r  = wr_en && idx == cdg_pkg::IDX_PB_RIGHT;
   assign wr_rec_l = wr_en && idx == cdg_pkg::IDX_REC_LEFT;
   assign wr_rec_r = wr_en && idx == cdg_pkg::IDX_REC_RIGHT;
   // apply strobes: either register of a pair carries the bit
   assign pb_apply  = (wr_pb_l || wr_pb_r) && pstrb_i[1] && pwdata_i[cdg_pkg::APPLY_BIT];
   assign rec_apply = (wr_rec_l || wr_rec_r) && pstrb_i[1] && pwdata_i[cdg_pkg::APPLY_BIT];

   // Pending codes as they stand after this cycle's write
   logic [7:0] pb_l_new;
   logic [7:0] pb_r_new;
   logic [7:0] rec_l_new;
   logic [7:0] rec_r_new;
   logic [7:0] pb_l_pend_q;
   logic [7:0] pb_r_pend_q;
   logic [7:0] rec_l_pend_q;
   logic [7:0] rec_r_pend_q;
   logic [7:0] pb_l_apply_q;
   logic [7:0] pb_r_apply_q;
   logic [7:0] rec_l_apply_q;
   logic [7:0] rec_r_apply_q;
   logic [15:0] st_q;
   logic [15:0] cond_q;
   assign pb_l_new  = (wr_pb_l && pstrb_i[0]) ? pwdata_i[7:0] : pb_l_pend_q;
   assign pb_r_new  = (wr_pb_r && pstrb_i[0]) ? pwdata_i[7:0] : pb_r_pend_q;
   assign rec_l_new = (wr_rec_l && pstrb_i[0]) ? pwdata_i[7:0] : rec_l_pend_q;
   assign rec_r_new = (wr_rec_r && pstrb_i[0]) ? pwdata_i[7:0] : rec_r_pend_q;

   // pending volumes only reach the gain stages on an apply strobe
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pb_l_pend_q   <= cdg_pkg::GAIN_RESET;
         pb_r_pend_q   <= cdg_pkg::GAIN_RESET;
         rec_l_pend_q  <= cdg_pkg::GAIN_RESET;
         rec_r_pend_q  <= cdg_pkg::GAIN_RESET;
         pb_l_apply_q  <= cdg_pkg::GAIN_RESET;
         pb_r_apply_q  <= cdg_pkg::GAIN_RESET;
         rec_l_apply_q <= cdg_pkg::GAIN_RESET;
         rec_r_apply_q <= cdg_pkg::GAIN_RESET;
      end else begin
         pb_l_pend_q  <= pb_l_new;
         pb_r_pend_q  <= pb_r_new;
         rec_l_pend_q <= rec_l_new;
         rec_r_pend_q <= rec_r_new;
         // both playback channels change on the same edge
         if (pb_apply) begin
            pb_l_apply_q <= pb_l_new;
            pb_r_apply_q <= pb_r_new;
         end
         // both record channels change on the same edge
         if (rec_apply) begin
            rec_l_apply_q <= rec_l_new;
            rec_r_apply_q <= rec_r_new;
         end
      end
   end

   // control registers; reserved bits are masked off and read zero
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q   <= '0;
         cond_q <= cdg_pkg::COND_RESET;
      end else if (wr_en && idx == cdg_pkg::IDX_SIDETONE) begin
         st_q   <= merge(st_q, cdg_pkg::ST_MASK);
      end else if (wr_en && idx == cdg_pkg::IDX_COND) begin
         cond_q <= merge(cond_q, cdg_pkg::COND_MASK);
      end
   end

   // Effective codes and control fields
   logic       silence;
   logic [7:0] pb_l_eff;
   logic [7:0] pb_r_eff;
   logic [7:0] rec_l_eff;
   logic [7:0] rec_r_eff;
   logic [7:0] tgt_l;
   logic [7:0] tgt_r;
   assign silence   = cond_q[cdg_pkg::COND_SILENCE];
   // playback codes above unity act as unity
   assign pb_l_eff  = clamp(pb_l_apply_q, cdg_pkg::GAIN_UNITY);
   assign pb_r_eff  = clamp(pb_r_apply_q, cdg_pkg::GAIN_UNITY);
   // record codes cap at the top boost step
   assign rec_l_eff = clamp(rec_l_apply_q, cdg_pkg::REC_GAIN_MAX);
   assign rec_r_eff = clamp(rec_r_apply_q, cdg_pkg::REC_GAIN_MAX);
   assign tgt_l     = silence ? cdg_pkg::GAIN_MUTE : pb_l_eff;
   assign tgt_r     = silence ? cdg_pkg::GAIN_MUTE : pb_r_eff;
   // analogue-side settings leave the block as levels
   assign sloped_filter_o     = cond_q[cdg_pkg::COND_SLOPED];
   assign pre_emphasis_undo_o = cond_q[cdg_pkg::COND_PRE_EMPHASIS_UNDO_SELECT +: 2];
   assign oversample_rate_o   = cond_q[cdg_pkg::COND_OSR];

   // Sample handshake into the two-entry buffer
   logic       accept;
   logic [1:0] count_q;
   assign in_ready_o = (count_q != 2'(DEPTH));
   assign accept     = in_valid_i && in_ready_o;

   // Ramp pacing counts accepted samples, so it tracks fs, not the clock
   logic [4:0] rate_cnt_q;
   logic [4:0] rate_last;
   logic       ramp_tick;
   logic       silence_q;
   logic       ramp_up_q;
   logic [7:0] cur_l_q;
   logic [7:0] cur_r_q;
   logic       ramping;
   logic       unsil_fall;
   // step every second or every thirty-second sample
   assign rate_last  = cond_q[cdg_pkg::COND_SPEED] ? cdg_pkg::RAMP_SLOW_LAST
                                                   : cdg_pkg::RAMP_FAST_LAST;
   assign ramp_tick  = accept && (rate_cnt_q >= rate_last);
   assign ramping    = silence || ramp_up_q;
   assign unsil_fall = silence_q && !silence;

   // current gain follows the target directly unless ramping or an unsilence ramp is starting
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rate_cnt_q <= '0;
         silence_q  <= 1'b0;
         ramp_up_q  <= 1'b0;
         cur_l_q    <= cdg_pkg::GAIN_RESET;
         cur_r_q    <= cdg_pkg::GAIN_RESET;
      end else begin
         silence_q  <= silence;
         rate_cnt_q <= ramp_tick ? '0 : accept ? rate_cnt_q + 5'h01 : rate_cnt_q;
         ramp_up_q  <= (unsil_fall && cond_q[cdg_pkg::COND_UNSIL])
                    || (ramp_up_q && !silence && !(cur_l_q == tgt_l && cur_r_q == tgt_r));
         if (!ramping && !(unsil_fall && cond_q[cdg_pkg::COND_UNSIL])) begin
            cur_l_q <= tgt_l;
            cur_r_q <= tgt_r;
         end else if (ramp_tick) begin
            cur_l_q <= step(cur_l_q, tgt_l);
            cur_r_q <= step(cur_r_q, tgt_r);
         end
      end
   end

   // Datapath: record gain, sidetone, playback gain, mono mix
   logic [SW-1:0] rec_l_g;
   logic [SW-1:0] rec_r_g;
   logic [SW-1:0] mix_l;
   logic [SW-1:0] mix_r;
   logic [SW-1:0] mono;
   logic [SW-1:0] push_l;
   logic [SW-1:0] push_r;
   assign rec_l_g = gain(rec_left_i, rec_l_eff);
   assign rec_r_g = gain(rec_right_i, rec_r_eff);
   // each playback channel adds its scaled sidetone source
   assign mix_l = add(gain(pb_left_i, cur_l_q),
      gain(st_pick(st_q[cdg_pkg::ST_SRC_L_LSB +: 2], rec_l_g, rec_r_g),
           st_code(st_q[cdg_pkg::ST_LEVEL_L_LSB +: 4])));
   assign mix_r = add(gain(pb_right_i, cur_r_q),
      gain(st_pick(st_q[cdg_pkg::ST_SRC_R_LSB +: 2], rec_l_g, rec_r_g),
           st_code(st_q[cdg_pkg::ST_LEVEL_R_LSB +: 4])));
   // half-sum keeps the mono mix within range
   assign mono   = SW'(((SW+1)'($signed(mix_l)) + (SW+1)'($signed(mix_r))) >>> 1);
   assign push_l = cond_q[cdg_pkg::COND_MONO] ? mono : mix_l;
   assign push_r = cond_q[cdg_pkg::COND_MONO] ? mono : mix_r;

   // Two-entry buffer; a stalled receiver stops intake through in_ready_o
   logic [FW-1:0] mem_q [DEPTH];
   logic          wr_ptr_q;
   logic          rd_ptr_q;
   logic          pop;
   assign out_valid_o = (count_q != 2'h0);
   assign pop         = out_valid_o && out_ready_i;
   assign {pb_left_o, pb_right_o, rec_left_o, rec_right_o} = mem_q[rd_ptr_q];

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= 2'h0;
      end else begin
         if (accept) begin
            mem_q[wr_ptr_q] <= {push_l, push_r, rec_l_g, rec_r_g};
            wr_ptr_q        <= !wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= !rd_ptr_q;
         end
         count_q <= count_q + 2'(accept) - 2'(pop);
      end
   end

   // Read data is captured in the setup cycle and stands through access
   logic [31:0] rd_mux;
   assign rd_mux =
        (idx == cdg_pkg::IDX_PB_LEFT)   ? {24'h0, pb_l_pend_q}
      : (idx == cdg_pkg::IDX_PB_RIGHT)  ? {24'h0, pb_r_pend_q}
      : (idx == cdg_pkg::IDX_REC_LEFT)  ? {24'h0, rec_l_pend_q}
      : (idx == cdg_pkg::IDX_REC_RIGHT) ? {24'h0, rec_r_pend_q}
      : (idx == cdg_pkg::IDX_SIDETONE)  ? {16'h0, st_q}
      : (idx == cdg_pkg::IDX_COND)      ? {16'h0, cond_q}
      : (idx == cdg_pkg::IDX_STATUS)    ? {15'h0, ramping, cur_r_q, cur_l_q}
      : 32'h0;

   // apply bits are never stored, so they read back as zero
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata_o <= '0;
      end else if (setup && !pwrite_i) begin
         prdata_o <= (hit ? rd_mux : 32'h0);
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_pb_apply_pair: assert property (pb_apply |=>
      pb_l_apply_q == $past(pb_l_new) && pb_r_apply_q == $past(pb_r_new))
      else $error("playback volumes not applied together");
   a_rec_apply_pair: assert property (rec_apply |=>
      rec_l_apply_q == $past(rec_l_new) && rec_r_apply_q == $past(rec_r_new))
      else $error("record volumes not applied together");
   a_pending_held: assert property (!pb_apply && !rec_apply |=>
      $stable(pb_l_apply_q) && $stable(pb_r_apply_q) && $stable(rec_l_apply_q))
      else $error("volume changed without apply");
   a_apply_reads_zero: assert property (access && !pwrite_i |->
      prdata_o[cdg_pkg::APPLY_BIT] == 1'b0 || idx == cdg_pkg::IDX_STATUS
      || idx == cdg_pkg::IDX_SIDETONE || idx == cdg_pkg::IDX_COND)
      else $error("apply bit read back as one");
   a_pb_gain_cap: assert property (cur_l_q <= cdg_pkg::GAIN_UNITY
      && cur_r_q <= cdg_pkg::GAIN_UNITY)
      else $error("playback gain above unity");
   a_rec_gain_cap: assert property (rec_l_eff <= cdg_pkg::REC_GAIN_MAX)
      else $error("record gain above ceiling");
   a_fast_ramp_rate: assert property (accept && !cond_q[cdg_pkg::COND_SPEED]
      && rate_cnt_q == cdg_pkg::RAMP_FAST_LAST |-> ramp_tick)
      else $error("fast ramp missed its step");
   a_silence_ramps: assert property (silence && ramp_tick && cur_l_q != 8'h00
      |=> cur_l_q == $past(cur_l_q) - 8'h01)
      else $error("silence ramp did not step down");
   a_unsil_jump: assert property (unsil_fall && !cond_q[cdg_pkg::COND_UNSIL]
      |=> cur_l_q == $past(pb_l_eff) && cur_r_q == $past(pb_r_eff))
      else $error("volume not restored at once");
   a_unsil_ramp: assert property (unsil_fall && cond_q[cdg_pkg::COND_UNSIL]
      |=> ramp_up_q && cur_l_q == $past(cur_l_q))
      else $error("volume jumped instead of ramping");
   a_mono_equal: assert property (accept && cond_q[cdg_pkg::COND_MONO]
      |-> push_l == push_r)
      else $error("mono mix differs between channels");
   a_buffer_hold: assert property (out_valid_o && !out_ready_i |=>
      out_valid_o && $stable(pb_left_o) && $stable(rec_left_o))
      else $error("buffered word lost under stall");
endmodule
`default_nettype wire

/* bench/cdg_host_model.sv */
`default_nettype none
// Host side of the sample streams: offers frames and drains results
module cdg_host_model (
   input  wire logic             clk_i,
   input  wire logic             in_ready_i,
   output logic                  in_valid_o,
   output logic [3:0][15:0]      frame_o,
   input  wire logic             out_valid_i,
   output logic                  out_ready_o,
   input  wire logic [3:0][15:0] result_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle at time zero; the sink stalls unless a result is wanted
   initial begin
      in_valid_o  = 1'b0;
      frame_o     = '0;
      out_ready_o = 1'b0;
   end

   // Held until an edge sees ready; then the lines are scrambled, not left stale
   task automatic send(input logic [3:0][15:0] f);
      @(posedge clk_i);
      in_valid_o <= 1'b1;
      frame_o    <= f;
      @(posedge clk_i);
      while (in_ready_i !== 1'b1) begin
         @(posedge clk_i);
      end
      in_valid_o <= 1'b0;
      frame_o    <= ~f;
   endtask

   // Ready only while a result is taken, so the buffer normally sees a stall
   task automatic recv(output logic [3:0][15:0] r);
      @(posedge clk_i);
      out_ready_o <= 1'b1;
      @(posedge clk_i);
      while (out_valid_i !== 1'b1) begin
         @(posedge clk_i);
      end
      r = result_i;
      out_ready_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] A_PBL = {cdg_pkg::IDX_PB_LEFT, 2'b00};
   localparam logic [9:0] A_PBR = {cdg_pkg::IDX_PB_RIGHT, 2'b00};
   localparam logic [9:0] A_ST  = {cdg_pkg::IDX_SIDETONE, 2'b00};
   localparam logic [9:0] A_CD  = {cdg_pkg::IDX_COND, 2'b00};
   localparam logic [9:0] A_RL  = {cdg_pkg::IDX_REC_LEFT, 2'b00};
   localparam logic [9:0] A_RR  = {cdg_pkg::IDX_REC_RIGHT, 2'b00};
   localparam logic [9:0] A_SS  = {cdg_pkg::IDX_STATUS, 2'b00};
   logic             core_clk_i;
   logic             sys_rst_i;
   logic             psel, penable, pwrite, pready, pslverr, er;
   logic [9:0]       paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [3:0]       pstrb;
   logic             in_valid, in_ready, out_valid, out_ready, sloped, osr;
   logic [1:0]       pre_emphasis_undo_select;
   logic [3:0][15:0] fr, res, dout;
   int               n_fail, check_count;

   cdg_gain_core DUT (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .in_valid_i(in_valid), .in_ready_o(in_ready), .pb_left_i(fr[0]), .pb_right_i(fr[1]),
      .rec_left_i(fr[2]), .rec_right_i(fr[3]), .out_valid_o(out_valid),
      .out_ready_i(out_ready), .pb_left_o(dout[0]), .pb_right_o(dout[1]),
      .rec_left_o(dout[2]), .rec_right_o(dout[3]), .sloped_filter_o(sloped),
      .pre_emphasis_undo_o(pre_emphasis_undo_select), .oversample_rate_o(osr));
   cdg_host_model host (
      .clk_i(core_clk_i), .in_ready_i(in_ready), .in_valid_o(in_valid), .frame_o(fr),
      .out_valid_i(out_valid), .out_ready_o(out_ready), .result_i(dout));

   // 50 MHz system clock
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // APB transfer; request held until pready is seen, result left in rd and er
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      @(posedge core_clk_i);
      while (pready !== 1'b1) begin
         @(posedge core_clk_i);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // One frame through the block; res holds the word the sink took
   task automatic frame(input logic [15:0] pl, pr, rl, rr);
      host.send({rr, rl, pr, pl});
      host.recv(res);
   endtask

   task automatic t_reset();
      apb(0, A_PBR, 0); chk(rd, 32'h00C0);
      apb(0, A_CD, 0); chk(rd, 0);
      apb(0, 10'h3FC, 0); chk({er, rd}, 33'h1_0000_0000);
      apb(1, A_PBR + 10'h1, 32'h100); chk(er, 1);
   endtask

   // Two frames fill the buffer while the sink stalls, none lost on drain
   task automatic t_buffer();
      logic [3:0][15:0] r;
      host.send({16'h4, 16'h3, 16'h2, 16'h1});
      host.send({16'h8, 16'h7, 16'h6, 16'h5});
      @(negedge core_clk_i); chk(in_ready, 0);
      host.recv(r); chk(r, {16'h4, 16'h3, 16'h2, 16'h1});
      host.recv(r); chk(r, {16'h8, 16'h7, 16'h6, 16'h5});
      @(negedge core_clk_i); chk({out_valid, in_ready}, 2'b01);
   endtask

   task automatic t_playback();
      apb(1, A_PBL, 0); frame(16'h1000, 16'h1000, 0, 0); chk(res[0], 16'h1000);
      apb(0, A_PBL, 0); chk(rd, 0);
      apb(1, A_PBR, 32'h1A0); frame(16'h1000, 16'h1000, 0, 0);
      chk({res[1], res[0]}, 32'h0400_0000);
      apb(1, A_PBL, 32'hFF); apb(1, A_PBR, 32'h1FF); frame(16'h1000, 16'h1000, 0, 0);
      chk({res[1], res[0]}, 32'h1000_1000);
   endtask

   task automatic t_record();
      apb(1, A_RL, 32'hFF); frame(0, 0, 16'h10, 16'h10); chk(res[2], 16'h10);
      apb(0, A_RL, 0); chk(rd, 32'hFF);
      apb(1, A_RR, 32'h1C0); frame(0, 0, 16'h10, 16'h10);
      chk({res[3], res[2]}, 32'h0010_007A);
      apb(1, A_RL, 32'h1EF); frame(0, 0, 16'h10, 16'h10); chk(res[2], 16'h7A);
      apb(1, A_RL, 32'h100); frame(0, 0, 16'h10, 16'h10); chk(res[2], 0);
      apb(1, A_RL, 32'h1C0);
   endtask

   task automatic t_mix();
      apb(1, A_ST, 32'hCC9); frame(16'h1000, 16'h2000, 16'h100, 16'h200);
      chk({res[1], res[0]}, 32'h2100_1200);
      apb(1, A_ST, 32'h9); frame(16'h1000, 16'h2000, 16'h100, 16'h200);
      chk({res[1], res[0]}, 32'h2004_1008);
      apb(1, A_ST, 32'hCCF); frame(16'h1000, 16'h2000, 16'h100, 16'h200);
      chk({res[1], res[0]}, 32'h2000_1000);
      apb(1, A_ST, 0); apb(1, A_CD, 32'h1000); frame(16'h1000, 16'h2000, 0, 0);
      chk({res[1], res[0]}, 32'h1800_1800);
      for (int i = 0; i < 4; i++) begin
         apb(1, A_CD, (i[0] << 11) | (i << 1) | i[1]); @(negedge core_clk_i);
         chk({sloped, pre_emphasis_undo_select, osr}, {i[0], i[1:0], i[1]});
      end
   endtask

   task automatic t_silence();
      apb(1, A_CD, 32'h8); repeat (100) frame(16'h1000, 16'h1000, 0, 0);
      apb(0, A_SS, 0); chk(rd[7:0] >= 8'h8B && rd[7:0] <= 8'h91 && rd[16], 1);
      repeat (300) frame(16'h1000, 16'h1000, 0, 0);
      apb(0, A_SS, 0); chk({rd, res[0]}, 48'h0001_0000_0000);
      apb(1, A_CD, 0); frame(16'h1000, 16'h1000, 0, 0); chk(res[0], 16'h1000);
      apb(0, A_SS, 0); chk(rd, 32'hC0C0);
      apb(1, A_CD, 32'h408); repeat (64) frame(16'h1000, 16'h1000, 0, 0);
      apb(0, A_SS, 0); chk(rd[7:0] >= 8'hBD && rd[7:0] <= 8'hBF, 1);
      apb(1, A_CD, 32'h208); repeat (400) frame(16'h1000, 16'h1000, 0, 0);
      apb(1, A_CD, 32'h200); repeat (20) frame(16'h1000, 16'h1000, 0, 0);
      apb(0, A_SS, 0); chk(rd[7:0] >= 8'h07 && rd[7:0] <= 8'h0B && rd[16], 1);
      chk(res[0] != 16'h1000 && res[0] != 0, 1);
      repeat (400) frame(16'h1000, 16'h1000, 0, 0);
      apb(0, A_SS, 0); chk({rd, res[0]}, 48'hC0C0_1000);
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Main sequence after a 12-cycle reset
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb     = 4'hF;
      sys_rst_i = 1'b1;
      repeat (12) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_buffer();
      t_playback();
      t_record();
      t_mix();
      t_silence();
      end_of_test();
   end

   // Roughly 1300 frames of a few cycles each; far beyond that means a hang
   initial begin
      #(20 * 60000);
      n_fail++;
      end_of_test();
   end
endmodule
`default_nettype wire
